// ### design/shpc_evt.sv
// shpc_evt: one sticky event flag with enable gating.
// assumes event and clear are single-cycle pulses on pclk.
`timescale 1ns/10ps
module shpc_evt
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // event, software clear and enable
    input wire logic event_i,
    input wire logic clear_i,
    input wire logic enable_i,
    // flag and gated request
    output logic flag_o,
    output logic req_o
);
    logic flag_q;
    logic flag_d;

    always_comb
    begin
        flag_d = flag_q;
        if (clear_i)
            flag_d = 1'b0;
        if (event_i)
            flag_d = 1'b1;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            flag_q <= 1'b0;
        else
            flag_q <= flag_d;
    end

    assign flag_o = flag_q;
    assign req_o = flag_q & enable_i;

    a_evt_sticky: assert property ( // RULE1 RULE2 RULE7
        @(posedge pclk) disable iff (!presetn)
        event_i |=> flag_q)
        else $error("event lost against clear");
endmodule

// ### design/shpc_top.sv
// shpc_top: slot hot-plug control register with APB slave,
// event flags, indicator message strobes and power control.
// assumes a single pclk domain and synchronous slot inputs.
// Overview of operation
// (RULE1) bit 3 enables presence-change interrupt or wake; resets zero
// (RULE2) bit 4 enables interrupt when a slot command completes
// (RULE3) bit 5 gates all hot-plug interrupts of individually enabled events
// (RULE4) attention field 7:6 on/blink/off, reset off; writes send message
// (RULE5) power field 9:8 same codes, reset off; writes send message
// (RULE6) bit 10 zero powers slot on, one powers off; resets zero
// (RULE7) bit 12 enables link-active change notice if capability present
// (RULE8) bit 11 reserved: reads zero, writes ignored
`timescale 1ns/10ps
module shpc_top
#(
    parameter bit DLL_CAP = 1'b1
)
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // slot events
    input wire logic presence_chg,
    input wire logic cmd_done,
    input wire logic link_active,
    // interrupt and wake
    output logic hp_irq,
    output logic hp_wake,
    // indicators and power
    output logic [1:0] attn_ind,
    output logic [1:0] pwr_ind,
    output logic slot_pwr_off,
    output logic msg_valid,
    output logic [1:0] msg_kind,
    output logic [1:0] msg_code
);
    logic [15:0] ctrl_q;
    logic [15:0] ctrl_d;
    logic msg_valid_q;
    logic msg_valid_d;
    logic [1:0] msg_kind_q;
    logic [1:0] msg_kind_d;
    logic [1:0] msg_code_q;
    logic [1:0] msg_code_d;
    logic [1:0] pend_q;
    logic [1:0] pend_d;
    logic link_q;
    logic [shpc_pkg::EV_W-1:0] ev_in;
    logic [shpc_pkg::EV_W-1:0] ev_clr;
    logic [shpc_pkg::EV_W-1:0] ev_en;
    logic [shpc_pkg::EV_W-1:0] ev_flag;
    logic [shpc_pkg::EV_W-1:0] ev_req;
    logic acc;
    logic wr;
    logic rd;
    logic hit;

    assign acc = psel & penable;
    assign wr = acc & pwrite;
    assign rd = acc & ~pwrite;
    assign hit = (paddr == shpc_pkg::SLOT_CTRL_ADDR)
        | (paddr == shpc_pkg::SLOT_EVT_ADDR)
        | (paddr == shpc_pkg::SLOT_STATE_ADDR);

    // link-active edge detect
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            link_q <= 1'b0;
        else
            link_q <= link_active;
    end

    assign ev_in[shpc_pkg::EV_PDC] = presence_chg;
    assign ev_in[shpc_pkg::EV_CC] = cmd_done;
    assign ev_in[shpc_pkg::EV_DLL] = DLL_CAP & (link_active ^ link_q);
    assign ev_en[shpc_pkg::EV_PDC] = ctrl_q[shpc_pkg::PDC_EN_BIT]; // RULE1
    assign ev_en[shpc_pkg::EV_CC] = ctrl_q[shpc_pkg::CC_EN_BIT]; // RULE2
    assign ev_en[shpc_pkg::EV_DLL] = ctrl_q[shpc_pkg::DLL_EN_BIT]; // RULE7

    // write-one-to-clear event flags
    genvar gi;
    generate
        for (gi = 0; gi < shpc_pkg::EV_W; gi++)
        begin : g_evt
            assign ev_clr[gi] = wr & (paddr == shpc_pkg::SLOT_EVT_ADDR)
                & pwdata[gi];
            shpc_evt u_evt
            (
                .pclk(pclk),
                .presetn(presetn),
                .event_i(ev_in[gi]),
                .clear_i(ev_clr[gi]),
                .enable_i(ev_en[gi]),
                .flag_o(ev_flag[gi]),
                .req_o(ev_req[gi])
            );
        end
    endgenerate

    assign hp_irq = ctrl_q[shpc_pkg::HP_EN_BIT] & (|ev_req); // RULE3
    assign hp_wake = ev_req[shpc_pkg::EV_PDC]; // RULE1

    // register, pending and message next state
    always_comb
    begin
        ctrl_d = ctrl_q;
        pend_d = pend_q;
        msg_valid_d = 1'b0;
        msg_kind_d = msg_kind_q;
        msg_code_d = msg_code_q;
        if (wr && paddr == shpc_pkg::SLOT_CTRL_ADDR)
        begin
            ctrl_d = (ctrl_q & ~shpc_pkg::SLOT_CTRL_WMASK)
                | (pwdata[15:0] & shpc_pkg::SLOT_CTRL_WMASK); // RULE8
            if (!DLL_CAP)
                ctrl_d[shpc_pkg::DLL_EN_BIT] = 1'b0; // RULE7
            pend_d = 2'h3; // RULE4 RULE5
        end
        else if (pend_q[0])
        begin
            msg_valid_d = 1'b1; // RULE4
            msg_kind_d = 2'(shpc_pkg::MSG_ATTN);
            msg_code_d = ctrl_q[shpc_pkg::ATTN_LO +: 2];
            pend_d[0] = 1'b0;
        end
        else if (pend_q[1])
        begin
            msg_valid_d = 1'b1; // RULE5
            msg_kind_d = 2'(shpc_pkg::MSG_PWR);
            msg_code_d = ctrl_q[shpc_pkg::PWRI_LO +: 2];
            pend_d[1] = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_q <= shpc_pkg::SLOT_CTRL_RST; // RULE4 RULE5 RULE6
            pend_q <= 2'h0;
            msg_valid_q <= 1'b0;
            msg_kind_q <= 2'(shpc_pkg::MSG_NONE);
            msg_code_q <= shpc_pkg::IND_RSVD;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            pend_q <= pend_d;
            msg_valid_q <= msg_valid_d;
            msg_kind_q <= msg_kind_d;
            msg_code_q <= msg_code_d;
        end
    end

    // zero-wait apb: data driven combinationally from registers
    assign pready = 1'b1;
    assign pslverr = acc & ~hit;
    always_comb
    begin
        prdata = 32'h0000_0000;
        if (rd)
        begin
            case (paddr)
                shpc_pkg::SLOT_CTRL_ADDR:
                    prdata[15:0] = ctrl_q; // RULE8
                shpc_pkg::SLOT_EVT_ADDR:
                    prdata[shpc_pkg::EV_W-1:0] = ev_flag;
                shpc_pkg::SLOT_STATE_ADDR:
                    prdata[0] = link_q;
                default:
                    prdata = 32'h0000_0000;
            endcase
        end
    end

    assign attn_ind = ctrl_q[shpc_pkg::ATTN_LO +: 2];
    assign pwr_ind = ctrl_q[shpc_pkg::PWRI_LO +: 2];
    assign slot_pwr_off = ctrl_q[shpc_pkg::PWR_OFF_BIT]; // RULE6
    assign msg_valid = msg_valid_q;
    assign msg_kind = msg_kind_q;
    assign msg_code = msg_code_q;

    a_rsvd_zero: assert property ( // RULE8
        @(posedge pclk) disable iff (!presetn)
        ctrl_q[shpc_pkg::RSVD11_BIT] == 1'b0)
        else $error("reserved bit 11 set");
    a_ctrl_msgs: assert property ( // RULE4
        @(posedge pclk) disable iff (!presetn)
        (wr && paddr == shpc_pkg::SLOT_CTRL_ADDR)
        ##1 !(wr && paddr == shpc_pkg::SLOT_CTRL_ADDR)
        |=> msg_valid_q && msg_kind_q == 2'(shpc_pkg::MSG_ATTN)
        && msg_code_q == ctrl_q[shpc_pkg::ATTN_LO +: 2])
        else $error("attention message missing");
    a_pwr_msg: assert property ( // RULE5
        @(posedge pclk) disable iff (!presetn)
        (msg_valid_q && msg_kind_q == 2'(shpc_pkg::MSG_ATTN) && !wr)
        |=> msg_valid_q && msg_kind_q == 2'(shpc_pkg::MSG_PWR)
        && msg_code_q == ctrl_q[shpc_pkg::PWRI_LO +: 2])
        else $error("power indicator message missing");
    a_irq_gate: assert property ( // RULE3
        @(posedge pclk) disable iff (!presetn)
        hp_irq |-> ctrl_q[shpc_pkg::HP_EN_BIT] && (|(ev_flag & ev_en)))
        else $error("interrupt without enable");
    a_pdc_irq: assert property ( // RULE1
        @(posedge pclk) disable iff (!presetn)
        (presence_chg && ctrl_q[shpc_pkg::PDC_EN_BIT]
            && ctrl_q[shpc_pkg::HP_EN_BIT] && !wr) |=> hp_irq)
        else $error("presence change interrupt missing");
    a_cc_irq: assert property ( // RULE2
        @(posedge pclk) disable iff (!presetn)
        (cmd_done && ctrl_q[shpc_pkg::CC_EN_BIT]
            && ctrl_q[shpc_pkg::HP_EN_BIT] && !wr) |=> hp_irq)
        else $error("command completed interrupt missing");
    a_dll_evt: assert property ( // RULE7
        @(posedge pclk) disable iff (!presetn)
        (DLL_CAP && $changed(link_active)) |=> ev_flag[shpc_pkg::EV_DLL])
        else $error("link change not flagged");
    a_pwr_ctl: assert property ( // RULE6
        @(posedge pclk) disable iff (!presetn)
        (wr && paddr == shpc_pkg::SLOT_CTRL_ADDR)
        |=> slot_pwr_off == $past(pwdata[shpc_pkg::PWR_OFF_BIT]))
        else $error("power control not updated");
endmodule

// ### dv/shpc_slot_model.sv
// shpc_slot_model: slot indicators and power controller partner.
// assumes msg strobes of shpc_top; tb drives go_pres and go_link.
`timescale 1ns/10ps
module shpc_slot_model
#(
    parameter int CMD_LAT = 5
)
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // indicator messages
    input wire logic msg_valid,
    input wire logic [1:0] msg_kind,
    input wire logic [1:0] msg_code,
    // stimulus requests
    input wire logic go_pres,
    input wire logic go_link,
    // slot events
    output logic presence_chg = 1'b0,
    output logic cmd_done = 1'b0,
    output logic link_active = 1'b0,
    // observed indicator state
    output logic [1:0] attn_seen = 2'h3,
    output logic [1:0] pwr_seen = 2'h3,
    output int msg_cnt = 0
);
    int busy = 0;
    // power message starts a command; done after CMD_LAT cycles
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            presence_chg <= 1'b0;
            cmd_done <= 1'b0;
            link_active <= 1'b0;
            busy <= 0;
        end
        else
        begin
            presence_chg <= go_pres;
            cmd_done <= (busy == 1);
            if (go_link)
                link_active <= ~link_active;
            if (busy != 0)
                busy <= busy - 1;
            if (msg_valid)
            begin
                msg_cnt <= msg_cnt + 1;
                if (msg_kind == shpc_pkg::MSG_ATTN)
                    attn_seen <= msg_code;
                if (msg_kind == shpc_pkg::MSG_PWR)
                begin
                    pwr_seen <= msg_code;
                    busy <= CMD_LAT;
                end
            end
        end
    end
endmodule

// ### dv/tb_top.sv
// tb_top: self-checking bench for shpc_top with slot model.
// assumes 250 MHz pclk and the register map of shpc_pkg.
`timescale 1ns/10ps
module tb_top;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, r, seed = 32'h19;
    logic pready, pslverr, presence_chg, cmd_done, link_active, hp_irq;
    logic hp_wake, slot_pwr_off, msg_valid, go_pres = 0, go_link = 0, err;
    logic [1:0] attn_ind, pwr_ind, msg_kind, msg_code, attn_seen, pwr_seen;
    logic [15:0] d, v;
    logic [15:0] en_m [3] = '{16'h0008, 16'h0010, 16'h1000};
    int msg_cnt, exp_cnt = 0, bad_count = 0, tests_run = 0;
    always #2 pclk = ~pclk;
    shpc_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .presence_chg, .cmd_done,
        .link_active, .hp_irq, .hp_wake, .attn_ind, .pwr_ind,
        .slot_pwr_off, .msg_valid, .msg_kind, .msg_code);
    shpc_slot_model i_slot (.pclk, .presetn, .msg_valid, .msg_kind,
        .msg_code, .go_pres, .go_link, .presence_chg, .cmd_done,
        .link_active, .attn_seen, .pwr_seen, .msg_cnt);
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    function automatic logic [31:0] exp_ctrl(input logic [15:0] x);
        return {16'h0000, x & shpc_pkg::SLOT_CTRL_WMASK};
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] dw);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= dw;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr_ctrl(input logic [15:0] dv);
        apb(1'b1, shpc_pkg::SLOT_CTRL_ADDR, {16'h0000, dv});
        exp_cnt += 2;
        repeat (12) @(posedge pclk);
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge pclk);
        bad_count++;
        wrap_up();
    end
    initial
    begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, shpc_pkg::SLOT_CTRL_ADDR, 32'h0);
        chk(r, 32'h0000_03C0);
        chk(slot_pwr_off, 1'b0);
        $display("test reset done");
        for (int i = 0; i < 12; i++)
        begin
            seed = xs(seed);
            d = seed[15:0];
            if (i < 4)
                d[9:6] = {i[1:0], i[1:0]};
            wr_ctrl(d);
            apb(1'b0, shpc_pkg::SLOT_CTRL_ADDR, 32'h0);
            chk(r, exp_ctrl(d));
            chk(attn_ind, d[7:6]);
            chk(attn_seen, d[7:6]);
            chk(pwr_ind, d[9:8]);
            chk(pwr_seen, d[9:8]);
            chk(slot_pwr_off, d[10]);
            chk(msg_cnt, exp_cnt);
        end
        $display("test fields done");
        for (int e = 0; e < 3; e++)
            for (int k = 0; k < 3; k++)
            begin
                v = 16'h03C0 | (k != 2 ? en_m[e] : 16'h0)
                    | (k != 0 ? 16'h0020 : 16'h0);
                wr_ctrl(v);
                apb(1'b1, shpc_pkg::SLOT_EVT_ADDR, 32'h7);
                repeat (2) @(posedge pclk);
                chk(hp_irq, 1'b0);
                go_pres <= (e == 0);
                go_link <= (e == 2);
                @(posedge pclk);
                go_pres <= 1'b0;
                go_link <= 1'b0;
                if (e == 1)
                    wr_ctrl(v);
                repeat (6) @(posedge pclk);
                chk(hp_irq, k == 1);
                if (e == 0)
                    chk(hp_wake, k != 2);
                apb(1'b0, shpc_pkg::SLOT_EVT_ADDR, 32'h0);
                chk(r, 32'h1 << e);
                apb(1'b0, shpc_pkg::SLOT_STATE_ADDR, 32'h0);
                chk(r, {31'h0, link_active});
            end
        $display("test events done");
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, shpc_pkg::SLOT_CTRL_ADDR, 32'h0);
        chk(r, 32'h0000_03C0);
        apb(1'b0, shpc_pkg::SLOT_EVT_ADDR, 32'h0);
        chk(r, 32'h0);
        chk(hp_irq, 1'b0);
        $display("test second reset done");
        apb(1'b0, 8'h0C, 32'h0);
        chk(err, 1'b1);
        chk(r, 32'h0);
        $display("test unmapped done");
        wrap_up();
    end
endmodule

// ### inc/shpc_pkg.sv
// shpc_pkg: offsets, field positions, encodings and reset values
// of the slot hot-plug control block; used by design/ files.
package shpc_pkg;
    // register byte addresses
    localparam logic [7:0] SLOT_CTRL_ADDR = 8'h00;
    localparam logic [7:0] SLOT_EVT_ADDR = 8'h04;
    localparam logic [7:0] SLOT_STATE_ADDR = 8'h08;
    // slot control field positions
    localparam int PDC_EN_BIT = 3;
    localparam int CC_EN_BIT = 4;
    localparam int HP_EN_BIT = 5;
    localparam int ATTN_LO = 6;
    localparam int PWRI_LO = 8;
    localparam int PWR_OFF_BIT = 10;
    localparam int RSVD11_BIT = 11;
    localparam int DLL_EN_BIT = 12;
    // event status bit positions
    localparam int EV_PDC = 0;
    localparam int EV_CC = 1;
    localparam int EV_DLL = 2;
    localparam int EV_W = 3;
    // indicator encodings
    localparam logic [1:0] IND_RSVD = 2'h0;
    localparam logic [1:0] IND_ON = 2'h1;
    localparam logic [1:0] IND_BLINK = 2'h2;
    localparam logic [1:0] IND_OFF = 2'h3;
    // reset values and writable mask of slot control
    localparam logic [15:0] SLOT_CTRL_RST = 16'h03C0;
    localparam logic [15:0] SLOT_CTRL_WMASK = 16'h17F8;
    // indicator message kinds
    typedef enum logic [1:0] {MSG_NONE, MSG_ATTN, MSG_PWR} shpc_msg_t;
endpackage
